/* core/ric_ctrl.sv */
// Purpose: reset combining and interrupt arbitration for a small CPU
// Assumes: rst_in is the power-on event; CPU pulses boundary at each instruction end
// Notes: stacking is driven as push/pop steps with a register index
// Notes on behaviour
// R01: Any reset source aborts work, restores defaults, fetches the reset vector.
// R02: Power-on holds reset 4064 clock cycles for clock stabilisation.
// R03: After the delay, reset stays while any source is still active.
// R04: Reset pin low for at least one and a half cycles makes a reset.
// R05: Reset sequence starts on the clock edge after the pin rises. The code starts it on the fifth edge, after the pin synchroniser.
// R06: Watchdog timeout resets; writing zero to bit 0 restarts it.
// R07: Opcode fetch outside RAM and EPROM makes a reset.
// R08: Interrupts are taken only once the current instruction completes.
// R09: Software interrupt enters regardless of mask or enables.
// R10: Pin events set a latch; entry happens at boundary if mask clear.
// R11: Entry clears the latch so new events latch during service.
// R12: Mask bit set blocks external and timer requests.
// R13: Option bit lets four low port pins feed the external path.
// R14: Sensitivity bit picks edge only or edge plus level triggering.
// R15: In level mode the latch stays set while a source holds level.
// R16: Other party spaces pin pulses by service cycles plus 19.
// R17: Real-time flag with its enable raises a timer request.
// R18: Overflow flag with its enable raises a timer request.
// R19: Entry stacks registers and sets mask; return restores them.
// R20: Entry fetches the vector of the serviced source.
// R21: Priority is reset, then external, then timer; software at instruction.
`timescale 1ns/1ps
`default_nettype none
`include "ric_cfg.svh"
module ric_ctrl
  import ric_pkg::*;
#(
  parameter logic [12:0] POR_CYCLES =
    13'((`RIC_POR_DELAY_TCYC * `RIC_TCYC_NS) / `RIC_CLK_PERIOD_NS),
  parameter logic [10:0] RAM_LO = 11'h0E0,
  parameter logic [10:0] RAM_HI = 11'h0FF,
  parameter logic [10:0] ROM_LO = 11'h200,
  parameter logic [10:0] ROM_HI = 11'h7FF
) (
  // Clock and power-on reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins
  input wire logic reset_pin_n_in,
  input wire logic irq_pin_n_in,
  input wire logic [3:0] porta_irq_in,
  // Timer and watchdog
  input wire logic wdog_timeout_in,
  input wire logic realtime_flag_in,
  input wire logic realtime_enable_in,
  input wire logic overflow_flag_in,
  input wire logic overflow_enable_in,
  // CPU side
  input wire logic fetch_in,
  input wire logic [`RIC_ADDR_W-1:0] fetch_addr_in,
  input wire logic boundary_in,
  input wire logic soft_int_in,
  input wire logic ret_int_in,
  input wire logic mask_set_in,
  input wire logic mask_clr_in,
  input wire logic stacked_mask_in,
  // Register port
  input wire logic [`RIC_ADDR_W-1:0] addr_in,
  input wire logic [`RIC_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`RIC_DATA_W-1:0] rdata_out,
  // Outputs to CPU and watchdog
  output logic cpu_reset_out,
  output logic vector_valid_out,
  output logic [`RIC_ADDR_W-1:0] vector_addr_out,
  output logic stack_push_out,
  output logic stack_pop_out,
  output logic [2:0] stack_index_out,
  output logic mask_out,
  output logic busy_out,
  output logic wdog_clear_out
);
  // ****************************************
  // Pin synchronisers and reset combining
  // ****************************************
  logic [2:0] rpin_s, irq_s;
  logic [3:0] pa_s1, pa_s2, pa_s3;
  logic rpin_lvl, irq_lvl;
  logic [3:0] pa_lvl;
  logic [12:0] por_cnt;
  logic ill_q;
  ric_cause_t cause;
  logic [2:0] next_rpin_s, next_irq_s;
  logic [3:0] next_pa_s1, next_pa_s2, next_pa_s3, next_pa_lvl;
  logic next_rpin_lvl, next_irq_lvl, next_ill, next_rst;
  logic [12:0] next_por_cnt;
  ric_cause_t next_cause;
  logic in_mem;

  always_comb begin
    next_rpin_s = {rpin_s[1:0], reset_pin_n_in};
    next_irq_s = {irq_s[1:0], irq_pin_n_in};
    next_pa_s1 = porta_irq_in;
    next_pa_s2 = pa_s1;
    next_pa_s3 = pa_s2;
    // Second and third stages must agree; one odd sample is ignored
    next_rpin_lvl = (rpin_s[1] == rpin_s[2]) ? rpin_s[2] : rpin_lvl; // R04
    next_irq_lvl = (irq_s[1] == irq_s[2]) ? irq_s[2] : irq_lvl;
    next_pa_lvl = ((pa_s2 ^ pa_s3) & pa_lvl) | (~(pa_s2 ^ pa_s3) & pa_s3);
    next_por_cnt = (por_cnt != 13'h0000) ? por_cnt - 13'h0001 : por_cnt; // R02
    in_mem = ((fetch_addr_in >= RAM_LO) && (fetch_addr_in <= RAM_HI)) ||
             ((fetch_addr_in >= ROM_LO) && (fetch_addr_in <= ROM_HI));
    next_ill = fetch_in && !in_mem && !cpu_reset_out; // R07
    // Release only when the delay is over and every source is gone
    next_rst = (por_cnt != 13'h0000) || !rpin_lvl || wdog_timeout_in || ill_q; // R01 R03 R06
    next_cause = cause;
    if (next_rst && !cpu_reset_out) begin
      next_cause = '0;
    end
    if (next_rst) begin
      next_cause.pin = next_cause.pin | !rpin_lvl;
      next_cause.wdog = next_cause.wdog | wdog_timeout_in;
      next_cause.ill = next_cause.ill | ill_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rpin_s <= 3'h7;
      irq_s <= 3'h7;
      pa_s1 <= 4'h0;
      pa_s2 <= 4'h0;
      pa_s3 <= 4'h0;
      rpin_lvl <= 1'b1;
      irq_lvl <= 1'b1;
      pa_lvl <= 4'h0;
      por_cnt <= POR_CYCLES; // R02
      ill_q <= 1'b0;
      cpu_reset_out <= 1'b1;
      cause <= 4'h1;
    end else begin
      rpin_s <= next_rpin_s;
      irq_s <= next_irq_s;
      pa_s1 <= next_pa_s1;
      pa_s2 <= next_pa_s2;
      pa_s3 <= next_pa_s3;
      rpin_lvl <= next_rpin_lvl;
      irq_lvl <= next_irq_lvl;
      pa_lvl <= next_pa_lvl;
      por_cnt <= next_por_cnt;
      ill_q <= next_ill;
      cpu_reset_out <= next_rst; // R05
      cause <= next_cause;
    end
  end

  // ****************************************
  // Interrupt latch and entry sequencer
  // ****************************************
  ric_state_t state, next_state;
  ric_src_t src, next_src;
  ric_opt_t opt;
  logic ext_latch, next_ext_latch, next_mask;
  logic [2:0] next_idx;
  logic next_push, next_pop, next_vvalid;
  logic [`RIC_ADDR_W-1:0] next_vaddr;
  logic ext_set, tmr_req, ext_ok, tmr_ok, enter;

  always_comb begin
    // Edge terms need a settled old level, so a glitch cannot fire twice
    ext_set = (irq_lvl && !next_irq_lvl) ||
              (opt.level && !irq_lvl); // R14 R15
    if (opt.porta) begin
      ext_set = ext_set || |(~pa_lvl & next_pa_lvl) ||
                (opt.level && |pa_lvl); // R13 R14
    end
    tmr_req = (realtime_flag_in && realtime_enable_in) ||
              (overflow_flag_in && overflow_enable_in); // R17 R18
    ext_ok = ext_latch && opt.ext_en && !mask_out; // R10 R12
    tmr_ok = tmr_req && !mask_out; // R12
    enter = boundary_in && !ret_int_in && (soft_int_in || ext_ok || tmr_ok); // R08
    next_src = src;
    if (soft_int_in) begin
      next_src = RIC_SRC_SOFT; // R09 R21
    end else if (ext_ok) begin
      next_src = RIC_SRC_EXT; // R21
    end else begin
      next_src = RIC_SRC_TMR;
    end
    next_state = state;
    next_idx = stack_index_out;
    next_mask = mask_out;
    next_ext_latch = ext_latch;
    if (state == ST_IDLE && enter && next_src == RIC_SRC_EXT) begin
      next_ext_latch = 1'b0; // R11
    end
    next_ext_latch = next_ext_latch || ext_set; // R10
    if (mask_set_in) begin
      next_mask = 1'b1;
    end else if (mask_clr_in) begin
      next_mask = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        next_idx = `RIC_STACK_FIRST;
        if (boundary_in && ret_int_in) begin
          next_state = ST_POP;
          next_idx = `RIC_STACK_LAST;
        end else if (enter) begin
          next_state = ST_PUSH;
          next_mask = 1'b1; // R19
        end
      end
      ST_RSTV: begin
        next_state = ST_IDLE;
      end
      ST_PUSH: begin
        if (stack_index_out == `RIC_STACK_LAST) begin
          next_state = ST_VEC;
        end else begin
          next_idx = stack_index_out + 3'h1; // R19
        end
      end
      ST_VEC: begin
        next_state = ST_IDLE;
      end
      ST_POP: begin
        if (stack_index_out == `RIC_STACK_LAST) begin
          next_mask = stacked_mask_in; // R19
        end
        if (stack_index_out == `RIC_STACK_FIRST) begin
          next_state = ST_IDLE;
        end else begin
          next_idx = stack_index_out - 3'h1;
        end
      end
    endcase
    if (state != ST_IDLE) begin
      next_src = src;
    end
    next_push = next_state == ST_PUSH;
    next_pop = next_state == ST_POP;
    next_vvalid = next_state == ST_VEC || next_state == ST_RSTV;
    unique case (src)
      RIC_SRC_SOFT: next_vaddr = `RIC_VEC_SOFT; // R20
      RIC_SRC_EXT: next_vaddr = `RIC_VEC_EXT; // R20
      RIC_SRC_TMR: next_vaddr = `RIC_VEC_TMR; // R20
      default: next_vaddr = `RIC_VEC_TMR;
    endcase
    if (next_state == ST_VEC && state == ST_PUSH) begin
      next_vaddr = next_vaddr;
    end
    if (next_state == ST_RSTV) begin
      next_vaddr = `RIC_VEC_RESET;
    end
    // Reset overrides everything, mid-instruction or mid-sequence
    if (cpu_reset_out) begin
      next_state = next_rst ? ST_IDLE : ST_RSTV; // R01
      next_src = RIC_SRC_SOFT;
      next_idx = `RIC_STACK_FIRST;
      next_mask = 1'b1;
      next_ext_latch = 1'b0;
      next_push = 1'b0;
      next_pop = 1'b0;
      next_vvalid = !next_rst;
      next_vaddr = `RIC_VEC_RESET; // R01
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      src <= RIC_SRC_SOFT;
      ext_latch <= 1'b0;
      mask_out <= 1'b1;
      stack_index_out <= `RIC_STACK_FIRST;
      stack_push_out <= 1'b0;
      stack_pop_out <= 1'b0;
      vector_valid_out <= 1'b0;
      vector_addr_out <= `RIC_VEC_RESET;
      busy_out <= 1'b0;
    end else begin
      state <= next_state;
      src <= next_src;
      ext_latch <= next_ext_latch;
      mask_out <= next_mask;
      stack_index_out <= next_idx;
      stack_push_out <= next_push;
      stack_pop_out <= next_pop;
      vector_valid_out <= next_vvalid;
      vector_addr_out <= next_vaddr;
      busy_out <= next_state != ST_IDLE;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  logic [`RIC_DATA_W-1:0] next_rdata;
  ric_opt_t next_opt;
  logic next_wclr;

  always_comb begin
    next_opt = opt;
    next_wclr = wr_in && addr_in == `RIC_WDOG_CLR_ADDR &&
                !wdata_in[`RIC_WDOG_CLR_BIT]; // R06
    if (wr_in && addr_in == `RIC_OPT_ADDR) begin
      next_opt.ext_en = wdata_in[`RIC_OPT_EXT_EN];
      next_opt.porta = wdata_in[`RIC_OPT_PORTA]; // R13
      next_opt.level = wdata_in[`RIC_OPT_LEVEL]; // R14
    end
    next_rdata = '0;
    if (rd_in && addr_in == `RIC_OPT_ADDR) begin
      next_rdata[`RIC_OPT_EXT_EN] = opt.ext_en;
      next_rdata[`RIC_OPT_PORTA] = opt.porta;
      next_rdata[`RIC_OPT_LEVEL] = opt.level;
    end else if (rd_in && addr_in == `RIC_STAT_ADDR) begin
      next_rdata[`RIC_STAT_EXT] = ext_latch;
      next_rdata[`RIC_STAT_TMR] = tmr_req;
      next_rdata[`RIC_STAT_MASK] = mask_out;
      next_rdata[`RIC_STAT_POR] = cause.por;
      next_rdata[`RIC_STAT_PIN] = cause.pin;
      next_rdata[`RIC_STAT_WDOG] = cause.wdog;
      next_rdata[`RIC_STAT_ILL] = cause.ill;
    end
    if (cpu_reset_out) begin
      next_opt = ric_opt_t'(3'(`RIC_OPT_RESET));
      next_wclr = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      opt <= ric_opt_t'(3'(`RIC_OPT_RESET));
      rdata_out <= '0;
      wdog_clear_out <= 1'b0;
    end else begin
      opt <= next_opt;
      rdata_out <= next_rdata;
      wdog_clear_out <= next_wclr;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_push_run;
    stack_push_out [*5] ##1 vector_valid_out;
  endsequence

  pin_reset_a: assert property (!rpin_lvl |=> cpu_reset_out) // R01
    else $error("pin low did not hold reset");
  por_hold_a: assert property (por_cnt != 13'h0000 |=> cpu_reset_out) // R02
    else $error("reset released during power-on delay");
  release_all_a: assert property ($fell(cpu_reset_out) |-> // R03
    $past(por_cnt) == 13'h0000 && $past(rpin_lvl) && !$past(wdog_timeout_in))
    else $error("reset released with a source active");
  wdog_clear_a: assert property (wr_in && !cpu_reset_out && // R06
    addr_in == `RIC_WDOG_CLR_ADDR && !wdata_in[`RIC_WDOG_CLR_BIT] |=> wdog_clear_out)
    else $error("watchdog clear write lost");
  illegal_fetch_a: assert property (fetch_in && !in_mem && !cpu_reset_out // R07
    |=> ##1 cpu_reset_out)
    else $error("illegal fetch gave no reset");
  entry_boundary_a: assert property ($rose(stack_push_out) |-> // R08
    $past(boundary_in))
    else $error("entry away from instruction boundary");
  soft_entry_a: assert property (state == ST_IDLE && boundary_in && soft_int_in && // R09
    !ret_int_in && !cpu_reset_out |=> stack_push_out && mask_out)
    else $error("software interrupt not entered");
  mask_block_a: assert property (state == ST_IDLE && boundary_in && mask_out && // R12
    !soft_int_in && !ret_int_in |=> !stack_push_out)
    else $error("masked request serviced");
  push_vector_a: assert property (disable iff (rst_in || cpu_reset_out) // R20
    $rose(stack_push_out) |-> s_push_run)
    else $error("push run not followed by vector");
endmodule : ric_ctrl
`default_nettype wire

/* dv/ric_cpu_model.sv */
// Purpose: CPU core stand-in that takes the stacking steps of ric_ctrl
// Assumes: one register per push or pop cycle
// Notes: logs the last five step indices for the bench
`timescale 1ns/1ps
`default_nettype none
module ric_cpu_model (
  // Clock
  input wire logic clk_in,
  // Stacking steps
  input wire logic stack_push_in,
  input wire logic stack_pop_in,
  input wire logic [2:0] stack_index_in,
  input wire logic mask_in,
  // Popped mask and logs
  output logic stacked_mask_out,
  output logic [14:0] push_log_out,
  output logic [14:0] pop_log_out
);
  logic last_mask;
  logic saved_mask;
  initial begin
    last_mask = 1'b1;
    saved_mask = 1'b1;
    push_log_out = 15'h0000;
    pop_log_out = 15'h0000;
  end
  always @(posedge clk_in) begin
    if (!stack_push_in && !stack_pop_in) last_mask <= mask_in;
    if (stack_push_in) push_log_out <= {push_log_out[11:0], stack_index_in};
    if (stack_push_in && stack_index_in == 3'h0) saved_mask <= last_mask;
    if (stack_pop_in) pop_log_out <= {pop_log_out[11:0], stack_index_in};
  end
  // Off the pop step the data bus is not ours: show the wrong value
  assign stacked_mask_out = (stack_pop_in && stack_index_in == 3'h4) ? saved_mask : !saved_mask;
endmodule : ric_cpu_model
`default_nettype wire

/* dv/ric_ctrl_tb.sv */
// Purpose: self-checking bench of ric_ctrl
// Assumes: POR_CYCLES shortened to 8
// Notes: CPU boundaries driven by hand, stacking answered by ric_cpu_model
`timescale 1ns/1ps
`default_nettype none
`include "ric_cfg.svh"
module ric_ctrl_tb;
  import ric_pkg::*;
  localparam int POR = 8;
  localparam logic [14:0] PUSH_ORDER = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  localparam logic [14:0] POP_ORDER = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  logic clk_in, rst_in, reset_pin_n_in, irq_pin_n_in, wdog_timeout_in;
  logic [3:0] porta_irq_in;
  logic realtime_flag_in, realtime_enable_in, overflow_flag_in, overflow_enable_in;
  logic fetch_in, boundary_in, soft_int_in, ret_int_in, mask_set_in, mask_clr_in, stacked_mask;
  logic [10:0] fetch_addr_in, addr_in, vector_addr_out;
  logic [7:0] wdata_in, rdata_out, rd_v;
  logic wr_in, rd_in, cpu_reset_out, vector_valid_out, stack_push_out, stack_pop_out;
  logic mask_out, busy_out, wdog_clear_out;
  logic [2:0] stack_index_out;
  logic [14:0] push_log, pop_log;
  int fail_count, n_checks;
  ric_ctrl #(.POR_CYCLES(13'(POR))) ric_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
    .reset_pin_n_in(reset_pin_n_in), .irq_pin_n_in(irq_pin_n_in),
    .porta_irq_in(porta_irq_in), .wdog_timeout_in(wdog_timeout_in),
    .realtime_flag_in(realtime_flag_in), .realtime_enable_in(realtime_enable_in),
    .overflow_flag_in(overflow_flag_in), .overflow_enable_in(overflow_enable_in),
    .fetch_in(fetch_in), .fetch_addr_in(fetch_addr_in), .boundary_in(boundary_in),
    .soft_int_in(soft_int_in), .ret_int_in(ret_int_in),
    .mask_set_in(mask_set_in), .mask_clr_in(mask_clr_in),
    .stacked_mask_in(stacked_mask), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .cpu_reset_out(cpu_reset_out),
    .vector_valid_out(vector_valid_out), .vector_addr_out(vector_addr_out),
    .stack_push_out(stack_push_out), .stack_pop_out(stack_pop_out),
    .stack_index_out(stack_index_out), .mask_out(mask_out), .busy_out(busy_out),
    .wdog_clear_out(wdog_clear_out));
  ric_cpu_model ric_cpu_model_i (.clk_in(clk_in), .stack_push_in(stack_push_out),
    .stack_pop_in(stack_pop_out), .stack_index_in(stack_index_out), .mask_in(mask_out),
    .stacked_mask_out(stacked_mask), .push_log_out(push_log), .pop_log_out(pop_log));
  // ****************************************
  // Bus and CPU step tasks
  // ****************************************
  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [10:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    rd_v = rdata_out;
  endtask : rd
  task automatic instr(input logic sw, input logic rt);
    @(posedge clk_in);
    boundary_in <= 1'b1;
    soft_int_in <= sw;
    ret_int_in <= rt;
    @(posedge clk_in);
    boundary_in <= 1'b0;
    soft_int_in <= 1'b0;
    ret_int_in <= 1'b0;
    #1;
  endtask : instr
  task automatic mask(input logic set);
    @(posedge clk_in);
    mask_set_in <= set;
    mask_clr_in <= !set;
    @(posedge clk_in);
    mask_set_in <= 1'b0;
    mask_clr_in <= 1'b0;
  endtask : mask
  // Entry up to the vector, then return; mask checked after return
  task automatic service(input logic sw, input logic [10:0] vec, input logic ret_mask);
    logic [10:0] got;
    got = 11'h000;
    instr(sw, 1'b0);
    for (int i = 0; i < 40 && got == 11'h000; i++) begin
      @(posedge clk_in);
      #1;
      if (vector_valid_out === 1'b1) got = vector_addr_out;
    end
    chk("vector", 15'(vec), 15'(got));
    chk("push_order", PUSH_ORDER, push_log);
    chk("mask_in_service", 15'h0001, 15'(mask_out));
    rd(`RIC_STAT_ADDR);
    instr(1'b0, 1'b1);
    repeat (8) @(posedge clk_in);
    #1;
    chk("pop_order", POP_ORDER, pop_log);
    chk("mask_restored", 15'(ret_mask), 15'(mask_out));
  endtask : service
  // Counts edges until release; sampled off the edge to avoid a race
  task automatic t_release(input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (cpu_reset_out === 1'b1 && n < 200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("hold_cycles", 15'h0001, 15'(n >= lo && n <= hi));
    chk("reset_vec_valid", 15'h0001, 15'(vector_valid_out));
    chk("reset_vec", 15'(`RIC_VEC_RESET), 15'(vector_addr_out));
  endtask : t_release
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd(`RIC_OPT_ADDR);
    chk("option_reset", 15'(`RIC_OPT_RESET), 15'(rd_v));
    rd(11'h7E0);
    chk("unmapped", 15'h0000, 15'(rd_v));
    wr(`RIC_WDOG_CLR_ADDR, 8'h01);
    #1;
    chk("wdog_no_clear", 15'h0000, 15'(wdog_clear_out));
    wr(`RIC_WDOG_CLR_ADDR, 8'h00);
    #1;
    chk("wdog_clear", 15'h0001, 15'(wdog_clear_out));
  endtask : t_regs
  task automatic t_src(input int k, input logic [7:0] cause);
    @(posedge clk_in);
    if (k == 0) wdog_timeout_in <= 1'b1;
    if (k == 1) reset_pin_n_in <= 1'b0;
    fetch_in <= (k == 2);
    fetch_addr_in <= (k == 2) ? 11'h100 : 11'h0E0;
    @(posedge clk_in);
    fetch_in <= 1'b0;
    // Illegal fetch is a one-cycle source, so its reset is short
    repeat ((k == 2) ? 1 : 12) @(posedge clk_in);
    #1;
    chk("held_by_source", 15'h0001, 15'(cpu_reset_out));
    @(posedge clk_in);
    wdog_timeout_in <= 1'b0;
    reset_pin_n_in <= 1'b1;
    t_release(0, 6);
    rd(`RIC_STAT_ADDR);
    chk("cause", 15'(cause), 15'(rd_v & 8'hF0));
    chk("mask_default", 15'h0001, 15'(mask_out));
  endtask : t_src
  task automatic t_ext;
    mask(1'b0);
    @(posedge clk_in);
    irq_pin_n_in <= 1'b0;
    realtime_flag_in <= 1'b1;
    realtime_enable_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    irq_pin_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(`RIC_STAT_ADDR);
    chk("ext_latched", 15'h0003, 15'(rd_v & 8'h03));
    instr(1'b0, 1'b0);
    #1;
    chk("entry_taken", 15'h0001, 15'(busy_out));
    repeat (10) @(posedge clk_in);
    rd(`RIC_STAT_ADDR);
    chk("latch_cleared", 15'h0000, 15'(rd_v & 8'h01));
    @(posedge clk_in);
    irq_pin_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    irq_pin_n_in <= 1'b1;
    instr(1'b0, 1'b1);
    repeat (30) @(posedge clk_in);
    service(1'b0, `RIC_VEC_EXT, 1'b0);
    service(1'b0, `RIC_VEC_TMR, 1'b0);
    @(posedge clk_in);
    realtime_flag_in <= 1'b0;
    overflow_flag_in <= 1'b1;
    overflow_enable_in <= 1'b1;
    mask(1'b1);
    instr(1'b0, 1'b0);
    #1;
    chk("masked_timer", 15'h0000, 15'(busy_out));
    mask(1'b0);
    service(1'b0, `RIC_VEC_TMR, 1'b0);
    @(posedge clk_in);
    overflow_flag_in <= 1'b0;
  endtask : t_ext
  task automatic t_porta;
    wr(`RIC_OPT_ADDR, 8'h05);
    porta_irq_in <= 4'h2;
    repeat (8) @(posedge clk_in);
    rd(`RIC_STAT_ADDR);
    chk("porta_off", 15'h0000, 15'(rd_v & 8'h01));
    wr(`RIC_OPT_ADDR, 8'h07);
    repeat (8) @(posedge clk_in);
    rd(`RIC_STAT_ADDR);
    chk("porta_level", 15'h0001, 15'(rd_v & 8'h01));
    // Unmasked so that entry really tries to clear the latch
    mask(1'b0);
    instr(1'b0, 1'b0);
    repeat (10) @(posedge clk_in);
    rd(`RIC_STAT_ADDR);
    chk("level_held", 15'h0001, 15'(rd_v & 8'h01));
  endtask : t_porta
  // ****************************************
  // Clock, sequence and verdict
  // ****************************************
  task automatic end_of_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = !clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    end_of_test();
  end
  initial begin
    {rst_in, reset_pin_n_in, irq_pin_n_in} = 3'b111;
    {wdog_timeout_in, fetch_in, boundary_in, soft_int_in, ret_int_in, wr_in, rd_in} = 7'h00;
    {realtime_flag_in, realtime_enable_in, overflow_flag_in, overflow_enable_in} = 4'h0;
    {mask_set_in, mask_clr_in, porta_irq_in} = 6'h00;
    fetch_addr_in = 11'h000;
    addr_in = 11'h000;
    wdata_in = 8'h00;
    fail_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_release(POR, POR + 1);
    t_regs();
    service(1'b1, `RIC_VEC_SOFT, 1'b1);
    t_ext();
    t_src(0, 8'h40);
    t_src(1, 8'h20);
    t_src(2, 8'h80);
    t_porta();
    end_of_test();
  end
endmodule : ric_ctrl_tb
`default_nettype wire

/* pkg/ric_cfg.svh */
// Purpose: constants of the reset and interrupt control block
// Assumes: 11-bit CPU address space, 8-bit data
// Notes: offsets, vectors, fields and timing counts
`ifndef RIC_CFG_SVH
`define RIC_CFG_SVH
`define RIC_ADDR_W 11
`define RIC_DATA_W 8
`define RIC_WDOG_CLR_ADDR 11'h7F0
`define RIC_OPT_ADDR 11'h7F2
`define RIC_STAT_ADDR 11'h7F3
`define RIC_VEC_RESET 11'h7FE
`define RIC_VEC_SOFT 11'h7FC
`define RIC_VEC_EXT 11'h7FA
`define RIC_VEC_TMR 11'h7F8
`define RIC_WDOG_CLR_BIT 0
`define RIC_OPT_EXT_EN 0
`define RIC_OPT_PORTA 1
`define RIC_OPT_LEVEL 2
`define RIC_OPT_RESET 8'h01
`define RIC_STAT_EXT 0
`define RIC_STAT_TMR 1
`define RIC_STAT_MASK 2
`define RIC_STAT_POR 4
`define RIC_STAT_PIN 5
`define RIC_STAT_WDOG 6
`define RIC_STAT_ILL 7
`define RIC_POR_DELAY_TCYC 4064
`define RIC_TCYC_NS 4
`define RIC_CLK_PERIOD_NS 4
`define RIC_STACK_LAST 3'h4
`define RIC_STACK_FIRST 3'h0
`endif

/* pkg/ric_pkg.sv */
// Purpose: types of the reset and interrupt control block
// Assumes: ric_cfg.svh holds the numbers
// Notes: none
`default_nettype none
package ric_pkg;
  typedef enum logic [1:0] {
    RIC_SRC_SOFT,
    RIC_SRC_EXT,
    RIC_SRC_TMR
  } ric_src_t;
  typedef enum {
    ST_IDLE,
    ST_RSTV,
    ST_PUSH,
    ST_VEC,
    ST_POP
  } ric_state_t;
  typedef struct packed {
    logic level;
    logic porta;
    logic ext_en;
  } ric_opt_t;
  typedef struct packed {
    logic ill;
    logic wdog;
    logic pin;
    logic por;
  } ric_cause_t;
endpackage : ric_pkg
`default_nettype wire
